//--- core/aecr_pkg.sv
package aecr_pkg;
	localparam int FRAME_BITS = 32;
	localparam logic [4:0] LAST_BIT = 5'h1F;
	localparam logic [11:0] HDR_PATTERN = 12'h001;
	localparam logic [3:0] ADDR_CFG = 4'h1;
	localparam logic [3:0] ADDR_OFS = 4'h2;
	localparam logic [3:0] ADDR_RSVD_C = 4'hC;
	localparam logic [3:0] ADDR_DES_EN = 4'hD;
	localparam logic [3:0] ADDR_DES_COARSE = 4'hE;
	localparam logic [3:0] ADDR_DES_FINE = 4'hF;
	localparam logic [15:0] CFG_RESET = 16'hB2FF;
	localparam logic [15:0] OFS_RESET = 16'h007F;
	localparam logic [15:0] DES_EN_RESET = 16'h3FFF;
	localparam logic [15:0] DES_PHASE_RESET = 16'h0000;
	localparam logic [7:0] OFS_MAG_ZERO = 8'h00;

	typedef struct packed {
		logic [11:0] header;
		logic [3:0] addr;
		logic [15:0] data;
	} aecr_frame_t;

	typedef struct packed {
		logic fixed_15;
		logic fixed_14;
		logic fixed_13;
		logic duty_stabilizer_enable;
		logic double_rate_clock_phase;
		logic single_rate_select;
		logic output_swing_select;
		logic edge_select;
		logic [7:0] fixed_low;
	} aecr_cfg_t;

	typedef struct packed {
		logic [7:0] magnitude;
		logic negative;
		logic [6:0] fixed_low;
	} aecr_ofs_t;
endpackage : aecr_pkg

//--- core/aecr_regs.sv
`timescale 1ns/1ps
// What this block does
// - Five write-only control registers, no readback
// - Settings act only in extended control mode
// - Ch reserved; Dh, Eh, Fh sampling registers
// - Configuration resets B2FF; fixed bits host-set
// - Bit 12 enables duty stabilizer, resets one
// - Bit 11 matters only in double rate
// - Bit 11 zero: clock edges on transitions
// - Bit 11 one: edges mid bit cell
// - Bit 10 zero: double data rate
// - Bit 10 one: single rate, edge by bit 8
// - Bit 9 selects swing, replaces swing pin
// - Bit 8 one: single rate rising edge
// - Bit 8 zero: single rate falling edge
// - Offset bits 15:8 linear magnitude, zero code
// - Offset bit 7 selects negative polarity
// - Offset resets 007F; low bits host-set
// - 32-bit frame MSB first: header, address, data
// - Sample on rising serial clock, select low
// - Back-to-back frames without select release
module aecr_regs
	import aecr_pkg::*;
#(
	parameter logic [15:0] DES_EN_INIT = DES_EN_RESET,
	parameter logic [15:0] DES_COARSE_INIT = DES_PHASE_RESET,
	parameter logic [15:0] DES_FINE_INIT = DES_PHASE_RESET
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic serial_clk,
	input wire logic serial_select_n,
	input wire logic serial_data_in,
	input wire logic extended_mode_pin,
	input wire logic swing_select_pin,
	input wire logic edge_select_pin,
	output logic duty_stabilizer_enable_q,
	output logic double_rate_clock_phase_q,
	output logic single_rate_select_q,
	output logic output_swing_select_q,
	output logic edge_select_q,
	output logic [7:0] offset_magnitude_q,
	output logic offset_negative_q,
	output logic [15:0] des_enable_q,
	output logic [15:0] des_coarse_q,
	output logic [15:0] des_fine_q
);
	// Link side: shift register and bit counter; only the counter is cleared whenever select is high
	logic [4:0] bit_cnt_q;
	logic [30:0] shift_q;
	aecr_frame_t hold_q;
	logic frame_tog_q;
	logic link_clr;

	assign link_clr = reset | serial_select_n;

	always_ff @(posedge serial_clk or posedge link_clr)
	begin
		if (link_clr)
			bit_cnt_q <= '0;
		else
			bit_cnt_q <= bit_cnt_q + 5'h01;
	end

	always_ff @(posedge serial_clk)
	begin
		shift_q <= {shift_q[29:0], serial_data_in};
	end

	// Holding word stays put for a whole frame, long enough to be read across
	always_ff @(posedge serial_clk or posedge reset)
	begin
		if (reset)
		begin
			hold_q <= '0;
			frame_tog_q <= 1'b0;
		end
		else if (!serial_select_n && bit_cnt_q == LAST_BIT)
		begin
			hold_q <= {shift_q, serial_data_in};
			frame_tog_q <= ~frame_tog_q;
		end
	end

	// System side synchronisers
	logic tog_s1_q, tog_s2_q, tog_s3_q;
	logic ext_s1_q, ext_s2_q;
	logic swing_s1_q, swing_s2_q;
	logic edge_s1_q, edge_s2_q;
	logic new_frame;
	logic hdr_ok;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
		end
		else
		begin
			tog_s1_q <= frame_tog_q;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			swing_s1_q <= 1'b1;
			swing_s2_q <= 1'b1;
			edge_s1_q <= 1'b0;
			edge_s2_q <= 1'b0;
		end
		else
		begin
			ext_s1_q <= extended_mode_pin;
			ext_s2_q <= ext_s1_q;
			swing_s1_q <= swing_select_pin;
			swing_s2_q <= swing_s1_q;
			edge_s1_q <= edge_select_pin;
			edge_s2_q <= edge_s1_q;
		end
	end

	assign new_frame = tog_s2_q ^ tog_s3_q;
	assign hdr_ok = (hold_q.header == HDR_PATTERN);

	// Write-only register store; nothing here is ever read back
	aecr_cfg_t cfg_q;
	aecr_ofs_t ofs_q;
	logic [15:0] des_en_reg_q;
	logic [15:0] des_coarse_reg_q;
	logic [15:0] des_fine_reg_q;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cfg_q <= CFG_RESET;
			ofs_q <= OFS_RESET;
			des_en_reg_q <= DES_EN_INIT;
			des_coarse_reg_q <= DES_COARSE_INIT;
			des_fine_reg_q <= DES_FINE_INIT;
		end
		else if (new_frame && hdr_ok && ext_s2_q)
		begin
			case (hold_q.addr)
				ADDR_CFG: cfg_q <= hold_q.data;
				ADDR_OFS: ofs_q <= hold_q.data;
				ADDR_DES_EN: des_en_reg_q <= hold_q.data;
				ADDR_DES_COARSE: des_coarse_reg_q <= hold_q.data;
				ADDR_DES_FINE: des_fine_reg_q <= hold_q.data;
				default: ;
			endcase
		end
	end

	// Effective controls; normal mode falls back to pins and power-on values
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			duty_stabilizer_enable_q <= 1'b1;
			double_rate_clock_phase_q <= 1'b0;
			single_rate_select_q <= 1'b0;
			output_swing_select_q <= 1'b1;
			edge_select_q <= 1'b0;
			offset_magnitude_q <= OFS_MAG_ZERO;
			offset_negative_q <= 1'b0;
			des_enable_q <= DES_EN_INIT;
			des_coarse_q <= DES_COARSE_INIT;
			des_fine_q <= DES_FINE_INIT;
		end
		else if (ext_s2_q)
		begin
			duty_stabilizer_enable_q <= cfg_q.duty_stabilizer_enable;
			double_rate_clock_phase_q <= cfg_q.double_rate_clock_phase
				& ~cfg_q.single_rate_select;
			single_rate_select_q <= cfg_q.single_rate_select;
			output_swing_select_q <= cfg_q.output_swing_select;
			edge_select_q <= cfg_q.edge_select;
			offset_magnitude_q <= ofs_q.magnitude;
			offset_negative_q <= ofs_q.negative;
			des_enable_q <= des_en_reg_q;
			des_coarse_q <= des_coarse_reg_q;
			des_fine_q <= des_fine_reg_q;
		end
		else
		begin
			duty_stabilizer_enable_q <= 1'b1;
			double_rate_clock_phase_q <= 1'b0;
			single_rate_select_q <= 1'b0;
			output_swing_select_q <= swing_s2_q;
			edge_select_q <= edge_s2_q;
			offset_magnitude_q <= OFS_MAG_ZERO;
			offset_negative_q <= 1'b0;
			des_enable_q <= DES_EN_INIT;
			des_coarse_q <= DES_COARSE_INIT;
			des_fine_q <= DES_FINE_INIT;
		end
	end

	sequence seq_good_write(logic [3:0] a);
		new_frame && hdr_ok && ext_s2_q && hold_q.addr == a;
	endsequence

	sequence seq_settle;
		ext_s2_q [*2];
	endsequence

	AST_CFG_STORE: assert property (@(posedge clk) disable iff (reset)
		seq_good_write(ADDR_CFG) |=> cfg_q == $past(hold_q.data))
		else $error("configuration write not stored");

	AST_BAD_HEADER: assert property (@(posedge clk) disable iff (reset)
		new_frame && !hdr_ok |=> $stable(cfg_q) && $stable(ofs_q) && $stable(des_en_reg_q))
		else $error("bad header changed a register");

	AST_RSVD_C: assert property (@(posedge clk) disable iff (reset)
		new_frame && hold_q.addr == ADDR_RSVD_C |=> $stable(cfg_q) && $stable(ofs_q)
		&& $stable(des_en_reg_q) && $stable(des_coarse_reg_q) && $stable(des_fine_reg_q))
		else $error("reserved slot changed a register");

	AST_DES_FINE: assert property (@(posedge clk) disable iff (reset)
		seq_good_write(ADDR_DES_FINE) ##1 ext_s2_q |=> des_fine_q == $past(hold_q.data, 2))
		else $error("fine phase write not applied");

	AST_NORMAL_SWING: assert property (@(posedge clk) disable iff (reset)
		!ext_s2_q |=> output_swing_select_q == $past(swing_s2_q)
		&& offset_magnitude_q == OFS_MAG_ZERO)
		else $error("register acted in normal mode");

	AST_PHASE_SDR: assert property (@(posedge clk) disable iff (reset)
		single_rate_select_q |-> !double_rate_clock_phase_q)
		else $error("phase active in single rate");

	AST_OFS_APPLY: assert property (@(posedge clk) disable iff (reset)
		seq_good_write(ADDR_OFS) ##1 seq_settle |-> offset_magnitude_q == $past(hold_q.data[15:8], 2)
		&& offset_negative_q == $past(hold_q.data[7], 2))
		else $error("offset not applied");

	AST_CFG_APPLY: assert property (@(posedge clk) disable iff (reset)
		seq_good_write(ADDR_CFG) ##1 seq_settle |-> output_swing_select_q == $past(hold_q.data[9], 2)
		&& duty_stabilizer_enable_q == $past(hold_q.data[12], 2))
		else $error("configuration not applied");

	AST_RESET_VALUES: assert property (@(posedge clk)
		reset |=> cfg_q == CFG_RESET && ofs_q == OFS_RESET)
		else $error("reset values wrong");

	AST_FRAME_LEN: assert property (@(posedge serial_clk) disable iff (link_clr)
		bit_cnt_q == LAST_BIT |=> frame_tog_q != $past(frame_tog_q) && bit_cnt_q == 5'h00)
		else $error("frame did not complete at 32 bits");

	// Quiet cycle: no frame has arrived from the link side
	sequence seq_idle;
		!new_frame;
	endsequence

	// Normal mode: every output falls back to its power-on value or its pin
	AST_NORMAL_DUTY: assert property (@(posedge clk) disable iff (reset)
		!ext_s2_q |=> duty_stabilizer_enable_q && !double_rate_clock_phase_q
		&& !single_rate_select_q)
		else $error("clocking setting acted in normal mode");

	AST_NORMAL_EDGE: assert property (@(posedge clk) disable iff (reset)
		!ext_s2_q |=> edge_select_q == $past(edge_s2_q) && !offset_negative_q)
		else $error("edge pin not followed in normal mode");

	AST_NORMAL_DES: assert property (@(posedge clk) disable iff (reset)
		!ext_s2_q |=> des_enable_q == DES_EN_INIT && des_coarse_q == DES_COARSE_INIT
		&& des_fine_q == DES_FINE_INIT)
		else $error("sampling register acted in normal mode");

	AST_NO_WRITE_NORMAL: assert property (@(posedge clk) disable iff (reset)
		new_frame && !ext_s2_q |=> $stable(cfg_q) && $stable(ofs_q)
		&& $stable(des_en_reg_q) && $stable(des_coarse_reg_q) && $stable(des_fine_reg_q))
		else $error("frame stored in normal mode");

	// Extended mode: every output follows its stored field one cycle later, phase masked by single rate
	AST_EXT_PHASE: assert property (@(posedge clk) disable iff (reset)
		ext_s2_q |=> double_rate_clock_phase_q == ($past(cfg_q.double_rate_clock_phase)
		&& !$past(cfg_q.single_rate_select)))
		else $error("clock phase not applied");

	AST_EXT_RATE: assert property (@(posedge clk) disable iff (reset)
		ext_s2_q |=> single_rate_select_q == $past(cfg_q.single_rate_select))
		else $error("rate select not applied");

	AST_EXT_EDGE: assert property (@(posedge clk) disable iff (reset)
		ext_s2_q |=> edge_select_q == $past(cfg_q.edge_select))
		else $error("edge select not applied");

	AST_EXT_DUTY: assert property (@(posedge clk) disable iff (reset)
		ext_s2_q |=> duty_stabilizer_enable_q == $past(cfg_q.duty_stabilizer_enable))
		else $error("duty stabilizer not applied");

	AST_EXT_SWING: assert property (@(posedge clk) disable iff (reset)
		ext_s2_q |=> output_swing_select_q == $past(cfg_q.output_swing_select))
		else $error("swing select not applied");

	AST_EXT_SIGN: assert property (@(posedge clk) disable iff (reset)
		ext_s2_q |=> offset_negative_q == $past(ofs_q.negative))
		else $error("offset sign not applied");

	AST_EXT_DES: assert property (@(posedge clk) disable iff (reset)
		ext_s2_q |=> des_enable_q == $past(des_en_reg_q)
		&& des_coarse_q == $past(des_coarse_reg_q))
		else $error("sampling registers not applied");

	// Register store: each accepted frame lands in its own slot only
	AST_OFS_STORE: assert property (@(posedge clk) disable iff (reset)
		seq_good_write(ADDR_OFS) |=> ofs_q == $past(hold_q.data) && $stable(cfg_q))
		else $error("offset write not stored");

	AST_DES_EN_STORE: assert property (@(posedge clk) disable iff (reset)
		seq_good_write(ADDR_DES_EN) |=> des_en_reg_q == $past(hold_q.data)
		&& $stable(cfg_q) && $stable(ofs_q))
		else $error("sampling enable write not stored");

	AST_DES_COARSE_STORE: assert property (@(posedge clk) disable iff (reset)
		seq_good_write(ADDR_DES_COARSE) |=> des_coarse_reg_q == $past(hold_q.data)
		&& $stable(des_fine_reg_q))
		else $error("coarse phase write not stored");

	AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (reset)
		seq_idle |=> $stable(cfg_q) && $stable(ofs_q) && $stable(des_en_reg_q)
		&& $stable(des_coarse_reg_q) && $stable(des_fine_reg_q))
		else $error("register changed without a frame");

	// Power-on state of the effective controls
	AST_RESET_OUTPUTS: assert property (@(posedge clk)
		reset |=> duty_stabilizer_enable_q && !double_rate_clock_phase_q
		&& !single_rate_select_q && output_swing_select_q && !edge_select_q)
		else $error("control reset values wrong");

	AST_RESET_OFFSET: assert property (@(posedge clk)
		reset |=> offset_magnitude_q == OFS_MAG_ZERO && !offset_negative_q
		&& des_enable_q == DES_EN_INIT)
		else $error("offset reset values wrong");
endmodule : aecr_regs

//--- verif/aecr_host.sv
`timescale 1ns/1ps
module aecr_host
	import aecr_pkg::*;
(
	input wire logic clk,
	input wire logic req,
	input wire aecr_frame_t frame,
	input wire logic [5:0] nbits,
	input wire logic hold_sel,
	output logic serial_clk,
	output logic serial_select_n,
	output logic serial_data_in,
	output logic busy
);
	logic [31:0] bits;
	int i;
	initial
	begin
		serial_clk = 1'b0;
		serial_select_n = 1'b1;
		serial_data_in = 1'b1;
		busy = 1'b0;
		forever
		begin
			@(posedge clk iff req);
			busy <= 1'b1;
			bits = frame;
			serial_select_n = 1'b0;
			for (i = 0; i < nbits; i++)
			begin
				serial_data_in = bits[31 - i];
				#3 serial_clk = 1'b1;
				#3 serial_clk = 1'b0;
			end
			// Select is raised after the bits unless hold_sel is set, aborting any frame shorter than 32 bits
			if (!hold_sel)
				serial_select_n = 1'b1;
			serial_data_in = ~serial_data_in;
			@(posedge clk);
			busy <= 1'b0;
		end
	end
endmodule : aecr_host

//--- verif/tb.sv
`timescale 1ns/1ps
module tb
	import aecr_pkg::*;
;
	logic clk, reset, ext, swp, edp, req, hold, sclk, sel_n, sdi, busy;
	logic duty, phase, single, swing, edg, neg;
	logic [5:0] nbits;
	logic [7:0] mag;
	logic [15:0] den, dco, dfi, cfg_e, ofs_e, den_e, dco_e, dfi_e;
	aecr_frame_t frm;
	int err_count, compares;
	aecr_regs dut (.clk(clk), .reset(reset), .serial_clk(sclk), .serial_select_n(sel_n),
		.serial_data_in(sdi), .extended_mode_pin(ext), .swing_select_pin(swp),
		.edge_select_pin(edp), .duty_stabilizer_enable_q(duty),
		.double_rate_clock_phase_q(phase), .single_rate_select_q(single),
		.output_swing_select_q(swing), .edge_select_q(edg), .offset_magnitude_q(mag),
		.offset_negative_q(neg), .des_enable_q(den), .des_coarse_q(dco), .des_fine_q(dfi));
	aecr_host host (.clk(clk), .req(req), .frame(frm), .nbits(nbits), .hold_sel(hold),
		.serial_clk(sclk), .serial_select_n(sel_n), .serial_data_in(sdi), .busy(busy));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	function automatic logic [15:0] exp_out(logic [15:0] c, logic [15:0] o, logic e, logic s,
		logic d);
		if (e)
			return {2'b00, c[12], c[11] & ~c[10], c[10], c[9], c[8], o[15:7]};
		return {5'h04, s, d, 9'h000};
	endfunction : exp_out
	task automatic end_of_test();
		$display("Compares %0d errors %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	task automatic chk(logic [15:0] got, logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic check_all();
		chk({2'b00, duty, phase, single, swing, edg, mag, neg},
			exp_out(cfg_e, ofs_e, ext, swp, edp));
		if (ext)
		begin
			chk(den, den_e);
			chk(dco, dco_e);
			chk(dfi, dfi_e);
		end
		else
		begin
			chk(den, DES_EN_RESET);
			chk(dco, DES_PHASE_RESET);
			chk(dfi, DES_PHASE_RESET);
		end
	endtask : check_all
	task automatic send(logic [11:0] h, logic [3:0] a, logic [15:0] d, logic [5:0] n, logic hs);
		int k;
		frm <= '{header: h, addr: a, data: d};
		nbits <= n;
		hold <= hs;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		for (k = 0; k < 200 && (k < 2 || busy); k++)
			@(posedge clk);
		if (k >= 200)
		begin
			err_count++;
			$display("Error %0t: host stuck", $time);
			end_of_test();
		end
		if (n == 6'h20 && h == HDR_PATTERN && ext)
			case (a)
				ADDR_CFG: cfg_e = d;
				ADDR_OFS: ofs_e = d;
				ADDR_DES_EN: den_e = d;
				ADDR_DES_COARSE: dco_e = d;
				ADDR_DES_FINE: dfi_e = d;
				default: ;
			endcase
		if (!hs)
			repeat (10) @(posedge clk);
	endtask : send
	initial
	begin
		int i;
		logic [31:0] r;
		reset = 1'b1;
		{ext, swp, edp, req, hold} = 5'h10;
		nbits = 6'h20;
		frm = '0;
		err_count = 0;
		compares = 0;
		{cfg_e, ofs_e, den_e} = {CFG_RESET, OFS_RESET, DES_EN_RESET};
		{dco_e, dfi_e} = 32'h0000_0000;
		r = $urandom(32'hAB7B1520);
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		repeat (10) @(posedge clk);
		check_all();
		for (i = 0; i < 32; i++)
		begin
			r = $urandom;
			send(HDR_PATTERN, ADDR_DES_EN, {1'b0, r[14:0]}, 6'h20, 1'b0);
			send(HDR_PATTERN, ADDR_DES_COARSE, r[31:16], 6'h20, 1'b1);
			send(HDR_PATTERN, ADDR_DES_FINE, r[15:0], 6'h20, 1'b0);
			send(HDR_PATTERN, ADDR_CFG, {3'h5, i[4:0], 8'hFF}, 6'h20, i[0]);
			send(HDR_PATTERN, ADDR_OFS, {r[24:16], 7'h7F}, 6'h20, 1'b0);
			check_all();
		end
		r = $urandom;
		send(r[11:0] | 12'h002, ADDR_CFG, 16'hA0FF, 6'h20, 1'b0);
		send(HDR_PATTERN, ADDR_RSVD_C, r[15:0], 6'h20, 1'b0);
		send(HDR_PATTERN, ADDR_CFG, 16'hA0FF, 6'h14, 1'b0);
		check_all();
		ext <= 1'b0;
		{swp, edp} <= 2'b11;
		repeat (10) @(posedge clk);
		check_all();
		send(HDR_PATTERN, ADDR_OFS, 16'hFFFF, 6'h20, 1'b0);
		{swp, edp} <= 2'b00;
		repeat (10) @(posedge clk);
		check_all();
		ext <= 1'b1;
		repeat (10) @(posedge clk);
		check_all();
		end_of_test();
	end
endmodule : tb
